//--- hw/power_manager_pkg.sv
// constants, field layout and carrier types of the telemetry register bank
// assumes a PMBus front end that decodes transactions into command strobes
package power_manager_pkg;
    localparam int NUM_CHANNELS = 8;
    localparam int DAC_BITS     = 10;
    // command codes of this bank
    localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
    localparam logic [7:0] CMD_VOUT_PEAK    = 8'h30;
    localparam logic [7:0] CMD_VIN_PEAK     = 8'h31;
    localparam logic [7:0] CMD_TEMP_PEAK    = 8'h32;
    localparam logic [7:0] CMD_DIRECT_DAC   = 8'h33;
    localparam logic [7:0] CMD_PG_DELAY     = 8'h34;
    localparam logic [7:0] CMD_PADS         = 8'h35;
    // reset values, DAC modes and code limit
    localparam logic [15:0] VOUT_PEAK_RESET = 16'hf800;
    localparam logic [15:0] VIN_PEAK_RESET  = 16'h7c00;
    localparam logic [15:0] TEMP_PEAK_RESET = 16'h7c00;
    localparam logic [15:0] PG_DELAY_RESET  = 16'h0000;
    localparam logic [9:0]  DAC_CODE_RESET  = 10'h000;
    localparam logic [1:0]  DAC_MODE_HARD   = 2'b10;
    localparam logic [1:0]  DAC_MODE_SOFT   = 2'b11;
    localparam logic [9:0]  DAC_CODE_MAX    = 10'h3ff;
    // field layout of the pad snapshot
    localparam int PAD_PWRGD_BIT = 15;
    localparam int PAD_ALERT_BIT = 14;
    localparam int PAD_RAW_BITS  = 10;
    // timing
    localparam int CLK_MHZ           = 125;
    localparam int PG_TICK_US        = 200;
    localparam int PG_TICK_CYCLES    = PG_TICK_US * CLK_MHZ;
    localparam int PG_TICKS_PER_MS   = 1000 / PG_TICK_US;
    localparam int PG_MAX_MS         = 13100;
    localparam int PG_MAX_TICKS      = PG_MAX_MS * 1000 / PG_TICK_US;
    localparam int SHARE_EDGES_TICK  = 20;
    localparam int SOFT_STEP_NS      = 1000;
    localparam int SOFT_STEP_CYCLES  = (SOFT_STEP_NS * CLK_MHZ + 999) / 1000;

    typedef enum logic [1:0] {ADC_VOUT, ADC_VIN, ADC_TEMP} adc_kind_type;
    typedef enum logic [1:0] {DAC_OFF, DAC_SEEK, DAC_LINKED} dac_state_type;

    typedef struct packed {
        logic         valid;
        adc_kind_type kind;
        logic [2:0]   channel;
        logic [15:0]  value;
    } adc_sample_type;

    typedef struct packed {
        logic        write;
        logic        read;
        logic [7:0]  code;
        logic [2:0]  page;
        logic [15:0] data;
    } pmbus_cmd_type;
endpackage

//--- hw/power_manager_telemetry_regs.sv
// peak telemetry, direct DAC, power-good delay and pad snapshot registers
// assumes ADC samples, channel state and DAC comparator come from core_clk
// logic; only the share clock and the pads arrive from outside
`timescale 1ns/100ps
`default_nettype none
module power_manager_telemetry_regs #(
    parameter int OSC_TICK_CYCLES  = power_manager_pkg::PG_TICK_CYCLES,
    parameter int SHARE_EDGES_TICK = power_manager_pkg::SHARE_EDGES_TICK,
    parameter int SOFT_STEP_CYCLES = power_manager_pkg::SOFT_STEP_CYCLES
) (
    // clock and reset
    input  wire logic                             core_clk,
    input  wire logic                             reset,
    // decoded command port
    input  wire power_manager_pkg::pmbus_cmd_type cmd,
    output logic [15:0]                           readData,
    output logic                                  readValid,
    // telemetry
    input  wire power_manager_pkg::adc_sample_type adcSample,
    // channel state and DAC
    input  wire logic [7:0]                       channelOn,
    input  wire logic [7:0]                       riseExpired,
    input  wire logic [7:0][1:0]                  dacMode,
    input  wire logic [7:0]                       dacAbove,
    output logic [7:0][9:0]                       dacCode,
    output logic [7:0]                            dacConnect,
    // power good
    input  wire logic [7:0]                       pgValid,
    input  wire logic [7:0]                       uvFastFault,
    input  wire logic [7:0]                       pgOffAdc,
    input  wire logic                             pwrgdOffUsesUv,
    input  wire logic                             shareClkPresent,
    input  wire logic                             shareClk,
    output logic [7:0]                            pgGood,
    output logic                                  pwrgdOut,
    output logic                                  pwrgdOe,
    // alert and fault lines
    input  wire logic                             alertDriveLow,
    output logic                                  alertOut,
    output logic                                  alertOe,
    input  wire logic [3:0]                       faultDriveLow,
    output logic [3:0]                            faultOut,
    output logic [3:0]                            faultOe,
    // raw pads: address_select_1, address_select_0, channel_control_1, channel_control_0, fault lines
    input  wire logic [9:0]                       padRaw
);
    import power_manager_pkg::*;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // scales an L11 word to a common fixed point so words compare directly
    function automatic logic signed [47:0] l11Scale(input logic [15:0] v);
        logic signed [47:0] m;
        logic [4:0]         sh;
        m  = {{37{v[10]}}, v[10:0]};
        sh = {~v[15], v[14:11]};
        return m <<< sh;
    endfunction

    // ms in L11 to 200us ticks, rounded to nearest, capped
    function automatic logic [15:0] l11ToTicks(input logic [15:0] v);
        logic [31:0] x;
        logic [31:0] t;
        logic [4:0]  n;
        x = 32'(v[9:0]) * 32'(PG_TICKS_PER_MS);
        n = 5'(~v[15:11] + 5'h01);
        if (v[10]) begin
            t = 32'h0;
        end else if (!v[15]) begin
            t = x << v[14:11];
        end else begin
            t = (x + (32'h1 << (n - 5'h01))) >> n;
        end
        return (t > 32'(PG_MAX_TICKS)) ? 16'(PG_MAX_TICKS) : t[15:0];
    endfunction

    logic       clearAny;
    logic [7:0] onRise;
    logic [7:0] channelOnPrev_reg;
    assign clearAny = cmd.write && (cmd.code == CMD_CLEAR_FAULTS);
    assign onRise   = channelOn & ~channelOnPrev_reg;

    // ------------------------------------------------------------
    // peak telemetry
    // ------------------------------------------------------------
    logic [7:0][15:0] voutPeak_reg;
    logic [7:0][15:0] voutPeak_next;
    logic [7:0]       voutEmpty_reg;
    logic [7:0]       voutEmpty_next;
    logic [15:0]      vinPeak_reg;
    logic [15:0]      vinPeak_next;
    logic [15:0]      tempPeak_reg;
    logic [15:0]      tempPeak_next;
    logic             globalClear;

    assign globalClear = clearAny || (|onRise);

    always_comb begin
        voutPeak_next  = voutPeak_reg;
        voutEmpty_next = voutEmpty_reg;
        vinPeak_next   = vinPeak_reg;
        tempPeak_next  = tempPeak_reg;
        for (int ch = 0; ch < NUM_CHANNELS; ch++) begin
            if ((clearAny && cmd.page == 3'(ch)) || onRise[ch]) begin
                voutPeak_next[ch]  = VOUT_PEAK_RESET;
                voutEmpty_next[ch] = 1'b1;
            end else if (adcSample.valid && adcSample.kind == ADC_VOUT &&
                         adcSample.channel == 3'(ch) &&
                         (voutEmpty_reg[ch] ||
                          adcSample.value > voutPeak_reg[ch])) begin
                // voutEmpty_reg marks the reset word, so the first sample always loads
                voutPeak_next[ch]  = adcSample.value;
                voutEmpty_next[ch] = 1'b0;
            end
        end
        if (globalClear) begin
            vinPeak_next  = VIN_PEAK_RESET;
            tempPeak_next = TEMP_PEAK_RESET;
        end else if (adcSample.valid) begin
            if (adcSample.kind == ADC_VIN &&
                l11Scale(adcSample.value) > l11Scale(vinPeak_reg)) begin
                vinPeak_next = adcSample.value;
            end
            if (adcSample.kind == ADC_TEMP &&
                l11Scale(adcSample.value) > l11Scale(tempPeak_reg)) begin
                tempPeak_next = adcSample.value;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            voutPeak_reg      <= {NUM_CHANNELS{VOUT_PEAK_RESET}};
            voutEmpty_reg     <= 8'hff;
            vinPeak_reg       <= VIN_PEAK_RESET;
            tempPeak_reg      <= TEMP_PEAK_RESET;
            channelOnPrev_reg <= 8'h00;
        end else begin
            voutPeak_reg      <= voutPeak_next;
            voutEmpty_reg     <= voutEmpty_next;
            vinPeak_reg       <= vinPeak_next;
            tempPeak_reg      <= tempPeak_next;
            channelOnPrev_reg <= channelOn;
        end
    end

    vinInit_a: assert property (globalClear |=> vinPeak_reg == 16'h7c00
        ) else $error("input peak not restarted");
    tempInit_a: assert property (globalClear |=> tempPeak_reg == 16'h7c00
        ) else $error("temperature peak not restarted");
    vinMax_a: assert property (!globalClear && !$past(globalClear) &&
        $changed(vinPeak_reg) |->
        l11Scale(vinPeak_reg) > l11Scale($past(vinPeak_reg))
        ) else $error("input peak fell");

    // ------------------------------------------------------------
    // time base: share clock edges or internal oscillator
    // ------------------------------------------------------------
    logic [2:0]  shareSync_reg;
    logic        shareLevel_reg;
    logic        shareLevel_next;
    logic [7:0]  shareCount_reg;
    logic [7:0]  shareCount_next;
    logic [15:0] oscCount_reg;
    logic [15:0] oscCount_next;
    logic [15:0] stepCount_reg;
    logic [15:0] stepCount_next;
    logic        shareTick;
    logic        oscTick;
    logic        pgTick;
    logic        stepTick;

    always_comb begin
        shareLevel_next = shareLevel_reg;
        shareCount_next = shareCount_reg;
        shareTick       = 1'b0;
        // a change counts once stages two and three agree
        if (shareSync_reg[1] == shareSync_reg[2] &&
            shareSync_reg[2] != shareLevel_reg) begin
            shareLevel_next = shareSync_reg[2];
            if (shareSync_reg[2]) begin
                if (shareCount_reg == 8'(SHARE_EDGES_TICK - 1)) begin
                    shareCount_next = 8'h00;
                    shareTick       = 1'b1;
                end else begin
                    shareCount_next = shareCount_reg + 8'h01;
                end
            end
        end
        oscTick        = (oscCount_reg == 16'(OSC_TICK_CYCLES - 1));
        oscCount_next  = oscTick ? 16'h0000 : oscCount_reg + 16'h0001;
        stepTick       = (stepCount_reg == 16'(SOFT_STEP_CYCLES - 1));
        stepCount_next = stepTick ? 16'h0000 : stepCount_reg + 16'h0001;
        pgTick         = shareClkPresent ? shareTick : oscTick;
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            shareSync_reg  <= 3'b000;
            shareLevel_reg <= 1'b0;
            shareCount_reg <= 8'h00;
            oscCount_reg   <= 16'h0000;
            stepCount_reg  <= 16'h0000;
        end else begin
            shareSync_reg  <= {shareSync_reg[1:0], shareClk};
            shareLevel_reg <= shareLevel_next;
            shareCount_reg <= shareCount_next;
            oscCount_reg   <= oscCount_next;
            stepCount_reg  <= stepCount_next;
        end
    end

    // ------------------------------------------------------------
    // per channel: direct DAC and power good
    // ------------------------------------------------------------
    logic [7:0][15:0] pgDelay_reg;
    logic [7:0][15:0] pgTarget;

    for (genvar ch = 0; ch < NUM_CHANNELS; ch++) begin : gChan
        dac_state_type dacState_reg;
        dac_state_type dacState_next;
        logic [9:0]    code_reg;
        logic [9:0]    code_next;
        logic [1:0]    modePrev_reg;
        logic          seekUp_reg;
        logic          seekUp_next;
        logic [15:0]   delay_next;
        logic [15:0]   pgCount_reg;
        logic [15:0]   pgCount_next;
        logic          good_reg;
        logic          good_next;
        logic          dacWrite;
        logic          offCond;

        assign dacWrite = cmd.write && cmd.code == CMD_DIRECT_DAC &&
                          cmd.page == 3'(ch);
        assign offCond  = pwrgdOffUsesUv ? uvFastFault[ch] : pgOffAdc[ch];
        assign pgTarget[ch] = l11ToTicks(pgDelay_reg[ch]);

        always_comb begin
            dacState_next = dacState_reg;
            code_next     = code_reg;
            seekUp_next   = seekUp_reg;
            if (!dacMode[ch][1]) begin
                dacState_next = DAC_OFF;
            end else if (dacMode[ch] != modePrev_reg &&
                         dacMode[ch] == DAC_MODE_HARD) begin
                dacState_next = DAC_LINKED;
            end else if (dacMode[ch] != modePrev_reg) begin
                dacState_next = DAC_SEEK;
                seekUp_next   = !dacAbove[ch];
            end else begin
                case (dacState_reg)
                    DAC_SEEK: begin
                        // a reversal means the code now brackets the node
                        if (stepTick) begin
                            if (dacAbove[ch] == seekUp_reg ||
                                (seekUp_reg && code_reg == DAC_CODE_MAX) ||
                                (!seekUp_reg && code_reg == 10'h000)) begin
                                dacState_next = DAC_LINKED;
                            end else if (seekUp_reg) begin
                                code_next = code_reg + 10'h001;
                            end else begin
                                code_next = code_reg - 10'h001;
                            end
                        end
                    end
                    DAC_OFF: dacState_next = DAC_OFF;
                    DAC_LINKED: dacState_next = DAC_LINKED;
                    default: dacState_next = DAC_OFF;
                endcase
            end
            if (dacWrite && channelOn[ch] && riseExpired[ch] &&
                dacMode[ch][1]) begin
                code_next = cmd.data[DAC_BITS-1:0];
            end

            delay_next = pgDelay_reg[ch];
            if (cmd.write && cmd.code == CMD_PG_DELAY &&
                cmd.page == 3'(ch)) begin
                delay_next = cmd.data;
            end
            pgCount_next = pgCount_reg;
            good_next    = good_reg;
            if (!pgValid[ch] || offCond) begin
                good_next    = 1'b0;
                pgCount_next = 16'h0000;
            end else if (!good_reg) begin
                if (pgCount_reg >= pgTarget[ch]) begin
                    good_next = 1'b1;
                end else if (pgTick) begin
                    pgCount_next = pgCount_reg + 16'h0001;
                end
            end
        end

        always_ff @(posedge core_clk) begin
            if (reset) begin
                dacState_reg    <= DAC_OFF;
                code_reg        <= DAC_CODE_RESET;
                modePrev_reg    <= 2'b00;
                seekUp_reg      <= 1'b0;
                pgDelay_reg[ch] <= PG_DELAY_RESET;
                pgCount_reg     <= 16'h0000;
                good_reg        <= 1'b0;
            end else begin
                dacState_reg    <= dacState_next;
                code_reg        <= code_next;
                modePrev_reg    <= dacMode[ch];
                seekUp_reg      <= seekUp_next;
                pgDelay_reg[ch] <= delay_next;
                pgCount_reg     <= pgCount_next;
                good_reg        <= good_next;
            end
        end

        assign dacCode[ch]    = code_reg;
        assign dacConnect[ch] = (dacState_reg == DAC_LINKED);
        assign pgGood[ch]     = good_reg;

        voutInit_a: assert property ((clearAny && cmd.page == 3'(ch)) |=>
            voutPeak_reg[ch] == 16'hf800 && voutEmpty_reg[ch]
            ) else $error("output peak not restarted");
        dacIgnore_a: assert property (dacWrite && !dacMode[ch][1] &&
            $stable(dacMode[ch]) |=> $stable(code_reg)
            ) else $error("write accepted in mode 0x");
        hardLink_a: assert property (!dacWrite && dacMode[ch] == 2'b10 &&
            modePrev_reg != 2'b10 |=> dacConnect[ch] &&
            code_reg == $past(code_reg)
            ) else $error("hard connect not immediate");
        pgWait_a: assert property ($rose(good_reg) |->
            $past(pgCount_reg) >= $past(pgTarget[ch])
            ) else $error("power good before delay");
        pgOffUv_a: assert property (pwrgdOffUsesUv && uvFastFault[ch] |=>
            !good_reg
            ) else $error("comparator did not drop power good");
        pgOffAdc_a: assert property (!pwrgdOffUsesUv && pgOffAdc[ch] |=>
            !good_reg
            ) else $error("polled threshold did not drop power good");
    end

    // ------------------------------------------------------------
    // pins and pad snapshot
    // ------------------------------------------------------------
    logic [PAD_RAW_BITS-1:0] pad1_reg;
    logic [PAD_RAW_BITS-1:0] pad2_reg;
    logic [PAD_RAW_BITS-1:0] pad3_reg;
    logic                    pwrgdDriveLow;
    logic [15:0]             padWord;

    // open drain: the pin only ever drives low, enable low means driving
    assign pwrgdDriveLow = ~(&pgGood);
    assign pwrgdOut      = 1'b0;
    assign pwrgdOe       = ~pwrgdDriveLow;
    assign alertOut      = 1'b0;
    assign alertOe       = ~alertDriveLow;
    assign faultOut      = 4'h0;
    assign faultOe       = ~faultDriveLow;

    // no deglitch here: the snapshot is the synchronised raw level
    assign padWord = {~pwrgdDriveLow, ~alertDriveLow,
                      ~faultDriveLow,
                      pad3_reg};

    always_ff @(posedge core_clk) begin
        if (reset) begin
            pad1_reg <= 10'h000;
            pad2_reg <= 10'h000;
            pad3_reg <= 10'h000;
        end else begin
            pad1_reg <= padRaw;
            pad2_reg <= pad1_reg;
            pad3_reg <= pad2_reg;
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    logic [15:0] readData_next;
    logic [15:0] readData_reg;
    logic        readValid_reg;

    always_comb begin
        case (cmd.code)
            CMD_VOUT_PEAK:  readData_next = voutPeak_reg[cmd.page];
            CMD_VIN_PEAK:   readData_next = vinPeak_reg;
            CMD_TEMP_PEAK:  readData_next = tempPeak_reg;
            CMD_DIRECT_DAC: readData_next = {6'h00, dacCode[cmd.page]};
            CMD_PG_DELAY:   readData_next = pgDelay_reg[cmd.page];
            CMD_PADS:       readData_next = padWord;
            default:        readData_next = 16'h0000;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            readData_reg  <= 16'h0000;
            readValid_reg <= 1'b0;
        end else begin
            if (cmd.read) begin
                readData_reg <= readData_next;
            end
            readValid_reg <= cmd.read;
        end
    end

    assign readData  = readData_reg;
    assign readValid = readValid_reg;

    delayRead_a: assert property (cmd.write && cmd.code == 8'h34 ##1
        cmd.read && cmd.code == 8'h34 && cmd.page == $past(cmd.page) |=>
        readData == $past(cmd.data, 2)
        ) else $error("delay read differs from write");
    padDrive_a: assert property (cmd.read && cmd.code == 8'h35 |=>
        readData[15] == $past(&pgGood) &&
        readData[13:10] == ~$past(faultDriveLow)
        ) else $error("pad drive bits wrong");
endmodule
`default_nettype wire

//--- bench/pmbus_host_model.sv
// host stand-in: registers each request and passes it on one cycle later as the command
// assumes requests change just after core_clk rising edges
`timescale 1ns/100ps
`default_nettype none
module pmbus_host_model (
    input  wire logic                             core_clk,
    input  wire power_manager_pkg::pmbus_cmd_type req,
    output var  power_manager_pkg::pmbus_cmd_type cmd
);
    import power_manager_pkg::*;
    always_ff @(posedge core_clk) begin
        cmd <= req;
    end
endmodule
`default_nettype wire

//--- bench/power_manager_telemetry_regs_tb.sv
// self-checking bench of the telemetry register bank
// assumes short tick parameters so delays stay a few cycles long
`timescale 1ns/100ps
`default_nettype none
module power_manager_telemetry_regs_tb;
    import power_manager_pkg::*;
    typedef struct packed {
        logic [7:0]  code;
        logic [15:0] exp;
    } row_type;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    pmbus_cmd_type req = '0;
    pmbus_cmd_type cmd;
    adc_sample_type adcSample = '0;
    logic [7:0] channelOn = '0, riseExpired = '0, dacAbove = '0;
    logic [7:0][1:0] dacMode = '0;
    logic [7:0] pgValid = '0, uvFastFault = '0, pgOffAdc = '0;
    logic pwrgdOffUsesUv = 1'b0, shareClkPresent = 1'b0, shareClk = 1'b0;
    logic alertDriveLow = 1'b0;
    logic [3:0] faultDriveLow = '0;
    logic [9:0] padRaw = '0;
    logic [15:0] readData, rd;
    logic readValid, pwrgdOe;
    logic [7:0] pgGood, dacConnect;
    int n_mismatch = 0;
    int checked = 0;
    row_type rows[5] = '{'{CMD_VOUT_PEAK, 16'hf800},
        '{CMD_VIN_PEAK, 16'h7c00}, '{CMD_TEMP_PEAK, 16'h7c00},
        '{CMD_DIRECT_DAC, 16'h0000}, '{CMD_PG_DELAY, 16'h0000}};

    pmbus_host_model u_pmbus_host_model (.core_clk(core_clk), .req(req),
        .cmd(cmd));
    power_manager_telemetry_regs #(.OSC_TICK_CYCLES(10),
        .SHARE_EDGES_TICK(2), .SOFT_STEP_CYCLES(2))
    u_power_manager_telemetry_regs (.core_clk(core_clk), .reset(reset),
        .cmd(cmd), .readData(readData), .readValid(readValid),
        .adcSample(adcSample), .channelOn(channelOn),
        .riseExpired(riseExpired), .dacMode(dacMode), .dacAbove(dacAbove),
        .dacCode(), .dacConnect(dacConnect), .pgValid(pgValid),
        .uvFastFault(uvFastFault), .pgOffAdc(pgOffAdc),
        .pwrgdOffUsesUv(pwrgdOffUsesUv), .shareClkPresent(shareClkPresent),
        .shareClk(shareClk), .pgGood(pgGood), .pwrgdOut(),
        .pwrgdOe(pwrgdOe), .alertDriveLow(alertDriveLow), .alertOut(),
        .alertOe(), .faultDriveLow(faultDriveLow), .faultOut(),
        .faultOe(), .padRaw(padRaw));

    initial begin
        forever #4 core_clk = ~core_clk;
    end

    task automatic chk(input string n, input logic [15:0] s, e);
        checked++;
        if (s !== e) begin
            n_mismatch++;
            $display("MISMATCH %s exp %h got %h", n, e, s);
        end
    endtask

    // one access; read data lands in rd, left unknown if none came
    task automatic acc(input logic w, input logic [7:0] c,
                       input logic [2:0] p, input logic [15:0] d);
        int i;
        rd = 'x;
        @(posedge core_clk);
        req <= '{write: w, read: !w, code: c, page: p, data: d};
        @(posedge core_clk);
        req <= '0;
        for (i = 0; i < 4; i++) begin
            @(posedge core_clk);
            #1;
            if (readValid === 1'b1) rd = readData;
        end
    endtask

    task automatic sample(input adc_kind_type k, input logic [15:0] v);
        @(posedge core_clk);
        adcSample <= '{valid: 1'b1, kind: k, channel: 3'h0, value: v};
        @(posedge core_clk);
        adcSample <= '0;
    endtask

    task automatic finish_test();
        if (n_mismatch == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        #200000;
        n_mismatch++;
        finish_test();
    end

    initial begin
        repeat (8) @(posedge core_clk);
        reset <= 1'b0;
        foreach (rows[i]) begin
            acc(1'b0, rows[i].code, 3'h0, 16'h0000);
            chk("reset value", rd, rows[i].exp);
        end
        acc(1'b1, CMD_PG_DELAY, 3'h0, 16'hd3a7);
        acc(1'b0, CMD_PG_DELAY, 3'h0, 16'h0000);
        chk("delay readback", rd, 16'hd3a7);
        sample(ADC_VIN, 16'h0100);
        sample(ADC_VIN, 16'h0010);
        acc(1'b0, CMD_VIN_PEAK, 3'h0, 16'h0000);
        chk("vin peak", rd, 16'h0100);
        sample(ADC_TEMP, 16'h0019);
        sample(ADC_VOUT, 16'h1000);
        acc(1'b0, CMD_VOUT_PEAK, 3'h0, 16'h0000);
        chk("vout peak", rd, 16'h1000);
        acc(1'b1, CMD_CLEAR_FAULTS, 3'h5, 16'h0000);
        acc(1'b0, CMD_TEMP_PEAK, 3'h0, 16'h0000);
        chk("temp clear", rd, 16'h7c00);
        acc(1'b0, CMD_VOUT_PEAK, 3'h0, 16'h0000);
        chk("vout other page", rd, 16'h1000);
        dacMode[0] <= DAC_MODE_HARD;
        acc(1'b1, CMD_DIRECT_DAC, 3'h0, 16'h0155);
        acc(1'b0, CMD_DIRECT_DAC, 3'h0, 16'h0000);
        chk("dac while off", rd, 16'h0000);
        channelOn <= 8'h01;
        riseExpired <= 8'h01;
        dacMode[0] <= 2'b01;
        acc(1'b1, CMD_DIRECT_DAC, 3'h0, 16'h0155);
        acc(1'b0, CMD_DIRECT_DAC, 3'h0, 16'h0000);
        chk("dac mode 01", rd, 16'h0000);
        dacMode[0] <= DAC_MODE_HARD;
        acc(1'b1, CMD_DIRECT_DAC, 3'h0, 16'hfff5);
        acc(1'b0, CMD_DIRECT_DAC, 3'h0, 16'h0000);
        chk("dac code", rd, 16'h03f5);
        chk("dac link", {15'h0, dacConnect[0]}, 16'h0001);
        padRaw <= 10'h2a5;
        alertDriveLow <= 1'b1;
        faultDriveLow <= 4'h4;
        repeat (3) @(posedge core_clk);
        acc(1'b0, CMD_PADS, 3'h0, 16'h0000);
        chk("pads", rd, 16'h2ea5);
        acc(1'b1, CMD_PG_DELAY, 3'h0, 16'h0000);
        pgValid <= 8'hff;
        repeat (5) @(posedge core_clk);
        #1;
        chk("power good", {pgGood, 7'h0, pwrgdOe}, 16'hff01);
        pwrgdOffUsesUv <= 1'b1;
        uvFastFault <= 8'h01;
        repeat (3) @(posedge core_clk);
        #1;
        chk("uv drop", {pgGood, 7'h0, pwrgdOe}, 16'hfe00);
        // comparator stays low, so the seek climbs to the top code
        dacMode[0] <= DAC_MODE_SOFT;
        repeat (40) @(posedge core_clk);
        acc(1'b0, CMD_DIRECT_DAC, 3'h0, 16'h0000);
        chk("soft code", rd, 16'h03ff);
        chk("soft link", {15'h0, dacConnect[0]}, 16'h0001);
        finish_test();
    end
endmodule
`default_nettype wire
